// [hw/rx_upload_defines.svh]
// Offsets, field positions, CRC constants and the address width of the receive upload engine
`ifndef RX_UPLOAD_DEFINES_SVH
`define RX_UPLOAD_DEFINES_SVH
`define REG_COMMAND        8'h00
`define REG_LIST_PTR       8'h04
`define REG_POLL           8'h08
`define REG_TOP_STATUS     8'h0C
`define REG_HASH_LO        8'h10
`define REG_HASH_HI        8'h14
`define REG_LIMIT          8'h18
`define REG_EVENTS         8'h1C
`define CMD_PAUSE          0
`define CMD_RESUME         1
`define CMD_DROP           2
`define CMD_HASH_EN        3
`define CMD_PROMISC_GRP    4
`define CMD_LIMIT_EN       5
`define ST_CRC_ERR         16
`define ST_ABORT           17
`define ST_IMPL_ABORT      18
`define ST_OVERFLOW        19
`define ST_GROUP           20
`define ST_FILLED          21
`define ST_DONE            22
`define LEN_MSB            14
`define DESC_STATUS_OFS    32'h0000_0004
`define DESC_FRAG_ADDR_OFS 32'h0000_0008
`define DESC_FRAG_LEN_OFS  32'h0000_000C
`define CRC_PRESET         32'hFFFF_FFFF
`define CRC_POLY           32'h04C1_1DB7
`define ADDR_BITS          48
`endif

// [hw/rx_upload_pkg.sv]
// Types of the receive upload engine
package rx_upload_pkg;
	typedef struct packed {
		logic        req;
		logic        wr;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bm_req_type;
	typedef struct packed {
		logic crc_err;
		logic abort;
		logic impl_abort;
		logic overrun;
	} rx_err_type;
	typedef enum logic [3:0] {
		S_IDLE, S_FETCH_STAT, S_CHECK_STAT, S_WAIT_FRAME, S_HASH, S_FETCH_FADDR, S_FETCH_FLEN,
		S_MOVE, S_WRITE_STAT, S_FETCH_NEXT, S_PURGE
	} state_type;
endpackage

// [hw/receive_upload_descriptor_engine.sv]
// Receive upload engine: moves frames from local buffer to host memory through receive descriptors
//
// What this block does
// - Fits: upload done; else descriptor needed.
// - Hash-failed group frame dropped silently.
// - Hash index is CRC low six bits.
// - Entry one uploads; entry zero discards silently.
// - Hash only frames with group address bit.
// - CRC uses 32-bit frame check polynomial.
// - No byte moves before hash result.
// - Passing group frame flagged in both status.
// - Software enables hashing; promiscuous group needed.
// - Link field chains; zero ends, loop rings.
// - Used descriptor fetched stalls the engine.
// - Full descriptor flagged filled, frame continues.
// - Last descriptor gets done, length, status.
// - Receive data reaches host by mastering only.
// - Lookahead full, no descriptor: needed, idle.
// - New descriptor acknowledges descriptor needed.
// - Length field is whole frame length; bytes moved so far when filled or cut at limit.
// - Status reports CRC, abort, implicit, overrun.
// - Errors only reported, never acted upon.
// - Upload limit: overflow in last, purge rest.
// - Zero pointer means no descriptors available.
// - Nonzero poll interval re-reads flags instead.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "rx_upload_defines.svh"
module receive_upload_descriptor_engine (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// Register port
	input  wire logic [7:0]                reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic [31:0]                    reg_rdata,
	// Bus master port to host memory
	output rx_upload_pkg::bm_req_type      bm_req,
	input  wire logic                      bm_ack,
	input  wire logic [31:0]               bm_rdata,
	// Top frame from local receive buffer
	input  wire logic                      frame_visible,
	input  wire logic                      frame_received,
	input  wire logic [14:0]               frame_length,
	input  wire logic [47:0]               frame_dest_addr,
	input  wire rx_upload_pkg::rx_err_type frame_errors,
	input  wire logic                      data_valid,
	input  wire logic [7:0]                data_byte,
	output logic                           data_pop,
	output logic                           drop_top_frame_cmd,
	// Events
	output logic                           upload_done_event,
	output logic                           descriptor_needed_event
);
	rx_upload_pkg::state_type  state_ff;
	rx_upload_pkg::bm_req_type bm_ff;
	logic [31:0] current_descriptor_pointer_ff;
	logic [31:0] poll_interval_ff;
	logic [31:0] poll_cnt_ff;
	logic [63:0] hash_table_ff;
	logic [14:0] limit_ff;
	logic        hash_en_ff;
	logic        promisc_grp_ff;
	logic        limit_en_ff;
	logic        paused_ff;
	logic        need_ff;
	logic [31:0] top_frame_status_ff;
	logic [31:0] frag_addr_ff;
	logic [31:0] frag_left_ff;
	logic [14:0] moved_ff;
	logic        group_ff;
	logic        filled_desc_ff;
	logic        overflow_ff;
	logic [31:0] crc_ff;
	logic [5:0]  crc_bit_ff;
	logic [31:0] rdata_ff;
	logic        drop_ff;
	logic        pop_ff;
	logic        done_ev_ff;
	logic        need_ev_ff;
	logic        cmd_wr;
	logic        bm_done;
	logic        frame_end;
	logic        over_limit;
	logic [31:0] nxt_crc;

	// One bit of the frame check generator, data taken least significant first
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
		crc_step = {c[30:0], 1'b0} ^ (((c[31] ^ b) == 1'b1) ? `CRC_POLY : 32'h0000_0000);
	endfunction

	// Descriptor status word (last or filled descriptor, and top status) built from the top frame
	function automatic logic [31:0] status_word(input logic done, input logic full, input logic ovf,
			input logic grp, input rx_upload_pkg::rx_err_type e, input logic [14:0] len);
		status_word = 32'h0000_0000;
		status_word[`LEN_MSB:0]     = len;
		status_word[`ST_CRC_ERR]    = e.crc_err;
		status_word[`ST_ABORT]      = e.abort;
		status_word[`ST_IMPL_ABORT] = e.impl_abort;
		status_word[`ST_OVERFLOW]   = e.overrun | ovf;
		status_word[`ST_GROUP]      = grp;
		status_word[`ST_FILLED]     = full;
		status_word[`ST_DONE]       = done;
	endfunction

	assign cmd_wr     = reg_wr && (reg_addr == `REG_COMMAND);
	assign bm_done    = bm_ff.req && bm_ack;
	assign frame_end  = frame_received && (moved_ff == frame_length);
	assign over_limit = limit_en_ff && (moved_ff == limit_ff) && !frame_end;
	assign nxt_crc    = crc_step(crc_ff, frame_dest_addr[crc_bit_ff]);

	// Configuration from software; errors are only reported, never acted on here
	always_ff @(posedge clk) begin
		if (rst) begin
			poll_interval_ff <= 32'h0000_0000;
			hash_table_ff    <= 64'h0000_0000_0000_0000;
			limit_ff         <= 15'h0000;
			hash_en_ff       <= 1'b0;
			promisc_grp_ff   <= 1'b0;
			limit_en_ff      <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				`REG_COMMAND: begin
					hash_en_ff     <= reg_wdata[`CMD_HASH_EN];
					promisc_grp_ff <= reg_wdata[`CMD_PROMISC_GRP];
					limit_en_ff    <= reg_wdata[`CMD_LIMIT_EN];
				end
				`REG_POLL:    poll_interval_ff <= reg_wdata;
				`REG_HASH_LO: hash_table_ff[31:0] <= reg_wdata;
				`REG_HASH_HI: hash_table_ff[63:32] <= reg_wdata;
				`REG_LIMIT:   limit_ff <= reg_wdata[14:0];
				default: ;
			endcase
		end
	end

	// Pause and resume; an internal stall sets it too, and set wins over resume
	always_ff @(posedge clk) begin
		if (rst)
			paused_ff <= 1'b0;
		else if (state_ff == rx_upload_pkg::S_CHECK_STAT && poll_interval_ff == 32'h0000_0000 &&
				(bm_rdata[`ST_DONE] || bm_rdata[`ST_FILLED]) && bm_done)
			paused_ff <= 1'b1;
		else if (cmd_wr && reg_wdata[`CMD_PAUSE])
			paused_ff <= 1'b1;
		else if (cmd_wr && reg_wdata[`CMD_RESUME])
			paused_ff <= 1'b0;
	end

	// Register reads; frame data has no slave path
	always_ff @(posedge clk) begin
		if (rst)
			rdata_ff <= 32'h0000_0000;
		else if (reg_rd) begin
			case (reg_addr)
				`REG_COMMAND:    rdata_ff <= {26'h0, limit_en_ff, promisc_grp_ff, hash_en_ff, 2'h0, paused_ff};
				`REG_LIST_PTR:   rdata_ff <= current_descriptor_pointer_ff;
				`REG_POLL:       rdata_ff <= poll_interval_ff;
				`REG_TOP_STATUS: rdata_ff <= top_frame_status_ff;
				`REG_HASH_LO:    rdata_ff <= hash_table_ff[31:0];
				`REG_HASH_HI:    rdata_ff <= hash_table_ff[63:32];
				`REG_LIMIT:      rdata_ff <= {17'h0, limit_ff};
				`REG_EVENTS:     rdata_ff <= {31'h0, need_ff};
				default:         rdata_ff <= 32'h0000_0000;
			endcase
		end else
			rdata_ff <= 32'h0000_0000;
	end

	// Descriptor-needed stays pending until a new descriptor is supplied
	always_ff @(posedge clk) begin
		if (rst)
			need_ff <= 1'b0;
		else if (need_ev_ff)
			need_ff <= 1'b1;
		else if ((state_ff == rx_upload_pkg::S_FETCH_STAT || state_ff == rx_upload_pkg::S_CHECK_STAT) && bm_done &&
				!bm_rdata[`ST_DONE] && !bm_rdata[`ST_FILLED])
			need_ff <= 1'b0;
	end

	// Upload sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff                      <= rx_upload_pkg::S_IDLE;
			bm_ff                         <= '0;
			current_descriptor_pointer_ff <= 32'h0000_0000;
			poll_cnt_ff                   <= 32'h0000_0000;
			top_frame_status_ff           <= 32'h0000_0000;
			frag_addr_ff                  <= 32'h0000_0000;
			frag_left_ff                  <= 32'h0000_0000;
			moved_ff                      <= 15'h0000;
			group_ff                      <= 1'b0;
			filled_desc_ff                <= 1'b0;
			overflow_ff                   <= 1'b0;
			crc_ff                        <= `CRC_PRESET;
			crc_bit_ff                    <= 6'h00;
			drop_ff                       <= 1'b0;
			pop_ff                        <= 1'b0;
			done_ev_ff                    <= 1'b0;
			need_ev_ff                    <= 1'b0;
		end else begin
			drop_ff    <= 1'b0;
			pop_ff     <= 1'b0;
			done_ev_ff <= 1'b0;
			need_ev_ff <= 1'b0;
			if (bm_done)
				bm_ff.req <= 1'b0;
			top_frame_status_ff <= status_word(1'b0, 1'b0, overflow_ff, group_ff, frame_errors,
				frame_received ? frame_length : moved_ff);
			// Software may load the pointer only while the list is empty
			if (reg_wr && reg_addr == `REG_LIST_PTR && current_descriptor_pointer_ff == 32'h0000_0000 &&
					state_ff == rx_upload_pkg::S_IDLE)
				current_descriptor_pointer_ff <= {reg_wdata[31:3], 3'b000};
			if (cmd_wr && reg_wdata[`CMD_DROP] && state_ff == rx_upload_pkg::S_IDLE) begin
				drop_ff  <= 1'b1;
				moved_ff <= 15'h0000;
			end
			case (state_ff)
				rx_upload_pkg::S_IDLE: begin
					if (current_descriptor_pointer_ff != 32'h0000_0000 && !paused_ff) begin
						bm_ff <= '{req: 1'b1, wr: 1'b0, addr: current_descriptor_pointer_ff + `DESC_STATUS_OFS,
							wdata: 32'h0000_0000};
						state_ff <= rx_upload_pkg::S_CHECK_STAT;
					end
				end
				rx_upload_pkg::S_FETCH_STAT: begin
					if (bm_done) begin
						if (bm_rdata[`ST_DONE] || bm_rdata[`ST_FILLED]) begin
							state_ff    <= rx_upload_pkg::S_FETCH_STAT;
							poll_cnt_ff <= poll_interval_ff;
						end else
							state_ff <= rx_upload_pkg::S_WAIT_FRAME;
					end else if (!bm_ff.req && !paused_ff) begin
						if (poll_cnt_ff != 32'h0000_0000)
							poll_cnt_ff <= poll_cnt_ff - 32'h0000_0001;
						else
							bm_ff <= '{req: 1'b1, wr: 1'b0, addr: current_descriptor_pointer_ff + `DESC_STATUS_OFS,
								wdata: 32'h0000_0000};
					end
				end
				rx_upload_pkg::S_CHECK_STAT: begin
					if (bm_done) begin
						if (bm_rdata[`ST_DONE] || bm_rdata[`ST_FILLED]) begin
							state_ff    <= rx_upload_pkg::S_FETCH_STAT;
							poll_cnt_ff <= poll_interval_ff;
						end else
							state_ff <= rx_upload_pkg::S_WAIT_FRAME;
					end
				end
				rx_upload_pkg::S_WAIT_FRAME: begin
					if (frame_visible) begin
						crc_ff      <= `CRC_PRESET;
						crc_bit_ff  <= 6'h00;
						// A frame continued from a filled descriptor keeps its count and group flag
						overflow_ff <= 1'b0;
						group_ff    <= group_ff && moved_ff != 15'h0000;
						if (hash_en_ff && frame_dest_addr[`ADDR_BITS-1] && moved_ff == 15'h0000)
							state_ff <= rx_upload_pkg::S_HASH;
						else begin
							bm_ff <= '{req: 1'b1, wr: 1'b0, addr: current_descriptor_pointer_ff + `DESC_FRAG_ADDR_OFS,
								wdata: 32'h0000_0000};
							state_ff <= rx_upload_pkg::S_FETCH_FADDR;
						end
					end
				end
				rx_upload_pkg::S_HASH: begin
					crc_ff     <= nxt_crc;
					crc_bit_ff <= crc_bit_ff + 6'h01;
					if (crc_bit_ff == 6'(`ADDR_BITS - 1)) begin
						if (hash_table_ff[nxt_crc[5:0]] && promisc_grp_ff) begin
							group_ff <= 1'b1;
							bm_ff <= '{req: 1'b1, wr: 1'b0, addr: current_descriptor_pointer_ff + `DESC_FRAG_ADDR_OFS,
								wdata: 32'h0000_0000};
							state_ff <= rx_upload_pkg::S_FETCH_FADDR;
						end else begin
							drop_ff  <= 1'b1;
							state_ff <= rx_upload_pkg::S_IDLE;
						end
					end
				end
				rx_upload_pkg::S_FETCH_FADDR: begin
					if (bm_done) begin
						frag_addr_ff <= bm_rdata;
						bm_ff <= '{req: 1'b1, wr: 1'b0, addr: current_descriptor_pointer_ff + `DESC_FRAG_LEN_OFS,
							wdata: 32'h0000_0000};
						state_ff <= rx_upload_pkg::S_FETCH_FLEN;
					end
				end
				rx_upload_pkg::S_FETCH_FLEN: begin
					if (bm_done) begin
						frag_left_ff <= bm_rdata;
						state_ff     <= rx_upload_pkg::S_MOVE;
					end
				end
				rx_upload_pkg::S_MOVE: begin
					if (!bm_ff.req && !pop_ff) begin
						if (frame_end || over_limit) begin
							overflow_ff    <= over_limit;
							filled_desc_ff <= 1'b0;
							bm_ff <= '{req: 1'b1, wr: 1'b1, addr: current_descriptor_pointer_ff + `DESC_STATUS_OFS,
								wdata: status_word(1'b1, 1'b0, over_limit, group_ff, frame_errors,
								frame_end ? frame_length : moved_ff)};
							state_ff <= rx_upload_pkg::S_WRITE_STAT;
						end else if (frag_left_ff == 32'h0000_0000) begin
							filled_desc_ff <= 1'b1;
							bm_ff <= '{req: 1'b1, wr: 1'b1, addr: current_descriptor_pointer_ff + `DESC_STATUS_OFS,
								wdata: status_word(1'b0, 1'b1, 1'b0, group_ff, frame_errors, moved_ff)};
							state_ff <= rx_upload_pkg::S_WRITE_STAT;
						end else if (data_valid) begin
							bm_ff <= '{req: 1'b1, wr: 1'b1, addr: frag_addr_ff, wdata: {24'h0, data_byte}};
							pop_ff       <= 1'b1;
							frag_addr_ff <= frag_addr_ff + 32'h0000_0001;
							frag_left_ff <= frag_left_ff - 32'h0000_0001;
							moved_ff     <= moved_ff + 15'h0001;
						end
					end
				end
				rx_upload_pkg::S_WRITE_STAT: begin
					if (bm_done) begin
						if (filled_desc_ff)
							need_ev_ff <= 1'b1;
						else begin
							done_ev_ff <= 1'b1;
							drop_ff    <= !overflow_ff; // An overflowed frame is dropped once, by the purge
							moved_ff   <= 15'h0000;
						end
						bm_ff <= '{req: 1'b1, wr: 1'b0, addr: current_descriptor_pointer_ff, wdata: 32'h0000_0000};
						state_ff <= rx_upload_pkg::S_FETCH_NEXT;
					end
				end
				rx_upload_pkg::S_FETCH_NEXT: begin
					if (bm_done) begin
						current_descriptor_pointer_ff <= {bm_rdata[31:3], 3'b000};
						if (overflow_ff)
							state_ff <= rx_upload_pkg::S_PURGE;
						else if (filled_desc_ff && bm_rdata != 32'h0000_0000) begin
							bm_ff <= '{req: 1'b1, wr: 1'b0, addr: {bm_rdata[31:3], 3'b000} + `DESC_STATUS_OFS,
								wdata: 32'h0000_0000};
							state_ff <= rx_upload_pkg::S_CHECK_STAT;
						end else
							state_ff <= rx_upload_pkg::S_IDLE;
					end
				end
				rx_upload_pkg::S_PURGE: begin
					drop_ff  <= 1'b1;
					state_ff <= rx_upload_pkg::S_IDLE;
				end
				default: state_ff <= rx_upload_pkg::S_IDLE;
			endcase
		end
	end

	assign reg_rdata               = rdata_ff;
	assign bm_req                  = bm_ff;
	assign data_pop                = pop_ff;
	assign drop_top_frame_cmd      = drop_ff;
	assign upload_done_event       = done_ev_ff;
	assign descriptor_needed_event = need_ev_ff;
endmodule
`default_nettype wire

// [test/rx_upload_checker.sv]
// Port assertions for the receive upload engine
`timescale 1ns/10ps
`default_nettype none
module rx_upload_checker (
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      rst,
	// Register port
	input wire logic                      reg_rd,
	input wire logic [31:0]               reg_rdata,
	// Bus master port
	input wire rx_upload_pkg::bm_req_type bm_req,
	input wire logic                      bm_ack,
	// Frame source and events
	input wire logic                      frame_visible,
	input wire logic                      data_valid,
	input wire logic                      data_pop,
	input wire logic                      drop_top_frame_cmd,
	input wire logic                      upload_done_event,
	input wire logic                      descriptor_needed_event
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside a read answer");
	a_events_apart: assert property (!(upload_done_event && descriptor_needed_event))
		else $error("done and needed raised together");
	a_done_one_cycle: assert property (upload_done_event |=> !upload_done_event)
		else $error("upload done longer than one cycle");
	a_needed_one_cycle: assert property ($rose(descriptor_needed_event) |=> $fell(descriptor_needed_event))
		else $error("descriptor needed longer than one cycle");
	a_done_then_drop: assert property ($rose(upload_done_event) |-> ##[0:300] drop_top_frame_cmd)
		else $error("no internal drop after upload done");
	a_req_held: assert property (bm_req.req && !bm_ack |=> bm_req.req && $stable(bm_req))
		else $error("bus request changed before acknowledge");
	a_pop_valid_byte: assert property (data_pop |-> $past(data_valid))
		else $error("byte popped while none was available");
	a_write_framed: assert property (bm_req.req && bm_req.wr |-> frame_visible)
		else $error("host write with no visible frame");
	c_done: cover property (upload_done_event);
	c_needed: cover property (descriptor_needed_event);
	c_silent_drop: cover property (drop_top_frame_cmd && !upload_done_event);
endmodule
bind receive_upload_descriptor_engine rx_upload_checker rx_upload_checker_i (.clk(clk), .rst(rst), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .bm_req(bm_req), .bm_ack(bm_ack), .frame_visible(frame_visible), .data_valid(data_valid),
	.data_pop(data_pop), .drop_top_frame_cmd(drop_top_frame_cmd), .upload_done_event(upload_done_event),
	.descriptor_needed_event(descriptor_needed_event));
`default_nettype wire

// [test/host_memory_model.sv]
// Host memory answering the engine's bus master requests
`timescale 1ns/10ps
`default_nettype none
module host_memory_model (
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      rst,
	// Bus master port
	input wire rx_upload_pkg::bm_req_type bm_req,
	output logic                          bm_ack,
	output logic [31:0]                   bm_rdata,
	// Answer speed
	input wire logic                      slow
);
	logic [31:0] mem [logic [31:0]];
	logic [2:0]  wait_ff = 3'h0;
	logic [31:0] noise_ff = 32'h0;
	function automatic logic [31:0] peek(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : 32'h0;
	endfunction
	task automatic poke(input logic [31:0] a, input logic [31:0] d);
		mem[a] = d;
	endtask
	// Outside an answer the read bus moves every cycle so stale data cannot pass
	always @(posedge clk) begin
		noise_ff <= {noise_ff[30:0], ~noise_ff[31]} ^ 32'h1357_9BDF;
		bm_ack <= 1'b0;
		bm_rdata <= noise_ff;
		if (rst) begin
			wait_ff <= 3'h0;
		end else if (bm_ack) begin
			wait_ff <= 3'h0;
			if (bm_req.wr) mem[bm_req.addr] = bm_req.wdata;
		end else if (bm_req.req) begin
			if (wait_ff >= (slow ? 3'h3 : 3'h0)) begin
				bm_ack <= 1'b1;
				bm_rdata <= peek(bm_req.addr);
			end else begin
				wait_ff <= wait_ff + 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [test/receive_upload_descriptor_engine_tb_top.sv]
// Register-level tests of the receive upload engine
`timescale 1ns/10ps
`default_nettype none
`include "rx_upload_defines.svh"
module receive_upload_descriptor_engine_tb_top;
	localparam logic [31:0] DONE = 32'h1 << `ST_DONE;
	localparam logic [31:0] FILL = 32'h1 << `ST_FILLED;
	localparam logic [31:0] OVF  = 32'h1 << `ST_OVERFLOW;
	localparam logic [47:0] UNI  = 48'h0000_0000_0001;
	localparam logic [47:0] GRP  = 48'h8000_0000_0003;
	logic                      clk = 1'b0;
	logic                      rst = 1'b1;
	logic [7:0]                reg_addr = 8'h00;
	logic [31:0]               reg_wdata = 32'h0;
	logic                      reg_wr = 1'b0;
	logic                      reg_rd = 1'b0;
	logic [31:0]               reg_rdata;
	rx_upload_pkg::bm_req_type bm_req;
	logic                      bm_ack;
	logic [31:0]               bm_rdata;
	logic                      slow = 1'b0;
	logic                      frame_visible = 1'b0;
	logic                      frame_received = 1'b0;
	logic [14:0]               frame_length = 15'h0;
	logic [14:0]               idx = 15'h0;
	logic [47:0]               frame_dest_addr = 48'h0;
	rx_upload_pkg::rx_err_type frame_errors = '0;
	logic                      data_valid;
	logic [7:0]                data_byte;
	logic                      data_pop, drop_top_frame_cmd, upload_done_event, descriptor_needed_event;
	int                        error_cnt = 0, n_checks = 0, done_cnt = 0, need_cnt = 0, drop_cnt = 0, base, k;
	logic [31:0]               v;
	logic [63:0]               hash;
	receive_upload_descriptor_engine receive_upload_descriptor_engine_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bm_req(bm_req), .bm_ack(bm_ack),
		.bm_rdata(bm_rdata), .frame_visible(frame_visible), .frame_received(frame_received), .frame_length(frame_length),
		.frame_dest_addr(frame_dest_addr), .frame_errors(frame_errors), .data_valid(data_valid), .data_byte(data_byte),
		.data_pop(data_pop), .drop_top_frame_cmd(drop_top_frame_cmd), .upload_done_event(upload_done_event),
		.descriptor_needed_event(descriptor_needed_event));
	host_memory_model host_memory_model_i (.clk(clk), .rst(rst), .bm_req(bm_req), .bm_ack(bm_ack), .bm_rdata(bm_rdata),
		.slow(slow));
	function automatic logic [7:0] pat(input logic [14:0] i);
		return i[7:0] + 8'h30;
	endfunction
	// Bytes past the frame end show the inverse so a stray read is caught
	assign data_valid = frame_visible && (idx < frame_length);
	assign data_byte = data_valid ? pat(idx) : ~pat(idx);
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (data_pop) idx <= idx + 15'h1;
		if (drop_top_frame_cmd) frame_visible <= 1'b0;
		if (upload_done_event) done_cnt <= done_cnt + 1;
		if (descriptor_needed_event) need_cnt <= need_cnt + 1;
		if (drop_top_frame_cmd) drop_cnt <= drop_cnt + 1;
	end
	function automatic int cnt(input int sel);
		return sel == 0 ? done_cnt : (sel == 1 ? need_cnt : drop_cnt);
	endfunction
	function automatic logic [5:0] hash_index(input logic [47:0] a);
		logic [31:0] c;
		c = 32'hFFFF_FFFF;
		for (int i = 0; i < 48; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i]) ? 32'h04C1_1DB7 : 32'h0);
		return c[5:0];
	endfunction
	function automatic logic [31:0] stat(input logic [31:0] a);
		return host_memory_model_i.peek(a + `DESC_STATUS_OFS);
	endfunction
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic offer(input logic [31:0] a, input logic [31:0] flen, input logic [31:0] st);
		logic [31:0] p;
		logic [31:0] c;
		rd(`REG_COMMAND, c);
		c = c & 32'h0000_0038;
		wr(`REG_COMMAND, c | (32'h1 << `CMD_PAUSE));
		host_memory_model_i.poke(a, 32'h0);
		host_memory_model_i.poke(a + `DESC_STATUS_OFS, st);
		host_memory_model_i.poke(a + `DESC_FRAG_ADDR_OFS, a << 4);
		host_memory_model_i.poke(a + `DESC_FRAG_LEN_OFS, flen);
		rd(`REG_LIST_PTR, p);
		for (int i = 0; i < 50 && p != 32'h0; i++) rd(`REG_LIST_PTR, p);
		chk("pointer empty", 32'h0, p);
		wr(`REG_LIST_PTR, a);
		wr(`REG_COMMAND, c | (32'h1 << `CMD_RESUME));
	endtask
	task automatic frame(input logic [14:0] len, input logic [47:0] da, input rx_upload_pkg::rx_err_type e);
		@(posedge clk);
		idx <= 15'h0;
		frame_length <= len;
		frame_dest_addr <= da;
		frame_errors <= e;
		frame_visible <= 1'b1;
		frame_received <= 1'b1;
	endtask
	task automatic wait_evt(input int sel);
		int b;
		b = cnt(sel);
		for (int i = 0; i < 4000; i++) begin
			@(posedge clk);
			#1;
			if (cnt(sel) > b) return;
		end
		$display("mismatch event %0d expected %0d seen %0d", sel, b + 1, cnt(sel));
		error_cnt++;
		close_out();
	endtask
	task automatic bytes(input logic [31:0] a, input int first, input int n);
		for (int j = 0; j < n; j++) chk("byte", {24'h0, pat(15'(first + j))}, host_memory_model_i.peek(a + j) & 32'hFF);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(`REG_LIST_PTR, v);
		chk("pointer after reset", 32'h0, v);
		rd(8'h40, v);
		chk("unmapped read", 32'h0, v);
		offer(32'h100, 32'h10, 32'h0);
		wr(`REG_LIST_PTR, 32'h200);
		rd(`REG_LIST_PTR, v);
		chk("pointer kept", 32'h100, v);
		frame(15'd8, UNI, '0);
		wait_evt(0);
		chk("fit status", DONE | 32'd8, stat(32'h100));
		bytes(32'h1000, 0, 8);
		chk("needed count", 32'h0, need_cnt);
		offer(32'h200, 32'h8, 32'h0);
		frame(15'd20, UNI, '0);
		wait_evt(1);
		chk("lookahead flags", FILL, stat(32'h200) & (FILL | DONE));
		rd(`REG_EVENTS, v);
		chk("needed pending", 32'h1, v & 32'h1);
		offer(32'h300, 32'h20, 32'h0);
		wr(`REG_COMMAND, 32'h1 << `CMD_RESUME);
		wait_evt(0);
		chk("tail status", DONE | 32'd20, stat(32'h300));
		bytes(32'h3000, 8, 12);
		rd(`REG_EVENTS, v);
		chk("needed cleared", 32'h0, v & 32'h1);
		// A used descriptor must hold the engine until software hands it back
		offer(32'h500, 32'h10, DONE);
		frame(15'd4, UNI, '0);
		repeat (40) @(posedge clk);
		chk("bytes while stalled", 32'h0, {17'h0, idx});
		rd(`REG_COMMAND, v);
		chk("paused", 32'h1, v & 32'h1);
		host_memory_model_i.poke(32'h500 + `DESC_STATUS_OFS, 32'h0);
		wr(`REG_COMMAND, 32'h1 << `CMD_RESUME);
		wait_evt(0);
		chk("resumed status", DONE | 32'd4, stat(32'h500));
		slow <= 1'b1;
		for (k = 0; k < 4; k++) begin
			offer(32'h600 + 32'(k) * 32'h20, 32'h10, 32'h0);
			frame(15'd4, UNI, rx_upload_pkg::rx_err_type'(4'h8 >> k));
			wait_evt(0);
			chk("error status", DONE | (32'h1 << (16 + k)) | 32'd4, stat(32'h600 + 32'(k) * 32'h20));
		end
		slow <= 1'b0;
		hash = ~(64'h1 << hash_index(GRP));
		wr(`REG_HASH_LO, hash[31:0]);
		wr(`REG_HASH_HI, hash[63:32]);
		wr(`REG_COMMAND, (32'h1 << `CMD_HASH_EN) | (32'h1 << `CMD_PROMISC_GRP));
		offer(32'h700, 32'h10, 32'h0);
		base = done_cnt;
		frame(15'd6, GRP, '0);
		wait_evt(2);
		chk("silent drop", base, done_cnt);
		chk("bytes before hash", 32'h0, {17'h0, idx});
		hash = 64'h1 << hash_index(GRP);
		wr(`REG_HASH_LO, hash[31:0]);
		wr(`REG_HASH_HI, hash[63:32]);
		frame(15'd6, GRP, '0);
		wait_evt(0);
		chk("group status", DONE | (32'h1 << `ST_GROUP) | 32'd6, stat(32'h700));
		wr(`REG_HASH_LO, 32'h0);
		wr(`REG_HASH_HI, 32'h0);
		offer(32'h740, 32'h10, 32'h0);
		frame(15'd5, UNI, '0);
		wait_evt(0);
		chk("unicast passes", DONE | 32'd5, stat(32'h740));
		wr(`REG_COMMAND, 32'h1 << `CMD_LIMIT_EN);
		wr(`REG_LIMIT, 32'h4);
		offer(32'h780, 32'h10, 32'h0);
		frame(15'd10, UNI, '0);
		wait_evt(0);
		chk("limit flags", DONE | OVF, stat(32'h780) & (DONE | OVF | FILL));
		chk("byte past limit", 32'h0, host_memory_model_i.peek(32'h7804));
		repeat (20) @(posedge clk);
		chk("frame purged", 32'h0, {31'h0, frame_visible});
		wr(`REG_POLL, 32'h10);
		offer(32'h7C0, 32'h10, FILL);
		frame(15'd3, UNI, '0);
		repeat (30) @(posedge clk);
		chk("bytes while polling", 32'h0, {17'h0, idx});
		host_memory_model_i.poke(32'h7C0 + `DESC_STATUS_OFS, 32'h0);
		wait_evt(0);
		chk("polled status", DONE | 32'd3, stat(32'h7C0));
		frame(15'd3, UNI, '0);
		wr(`REG_COMMAND, 32'h1 << `CMD_DROP);
		repeat (3) @(posedge clk);
		chk("software drop", 32'h0, {31'h0, frame_visible});
		close_out();
	end
endmodule
`default_nettype wire
